//--- core/pwr_down_pkg.sv
// constants and types for the power-down mode controller
package pwr_down_pkg;
   localparam int level_w = 2;
   localparam logic [1:0] level_active = 2'h0;
   localparam logic [1:0] level_light = 2'h1;
   localparam logic [1:0] level_deep = 2'h2;
   localparam logic [1:0] level_deepest = 2'h3;
   localparam int sync_depth = 3;
   typedef enum logic [1:0] {st_active, st_light, st_deep, st_deepest} pd_state_t;
endpackage

//--- core/wake_if.sv
// synchronised wake sources shared between the sync module and the controller
`timescale 1ns/100ps
interface wake_if;
   logic timer_wake;
   logic ext_wake;
   modport src (output timer_wake, output ext_wake);
   modport dst (input timer_wake, input ext_wake);
endinterface

//--- core/wake_sync.sv
// three-stage synchroniser for the two asynchronous wake pins
`timescale 1ns/100ps
module wake_sync (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // raw pins
   input wire logic timer_irq_pin_in,
   input wire logic ext_irq_pin_in,
   // synchronised levels
   wake_if.src wake
);
   logic [pwr_down_pkg::sync_depth-1:0] timer_sh_ff;
   logic [pwr_down_pkg::sync_depth-1:0] ext_sh_ff;
   logic [pwr_down_pkg::sync_depth-1:0] nxt_timer_sh;
   logic [pwr_down_pkg::sync_depth-1:0] nxt_ext_sh;
   logic timer_lvl_ff;
   logic ext_lvl_ff;
   logic nxt_timer_lvl;
   logic nxt_ext_lvl;

   always_comb begin
      nxt_timer_sh = {timer_sh_ff[pwr_down_pkg::sync_depth-2:0], timer_irq_pin_in};
      nxt_ext_sh = {ext_sh_ff[pwr_down_pkg::sync_depth-2:0], ext_irq_pin_in};
      nxt_timer_lvl = timer_lvl_ff;
      nxt_ext_lvl = ext_lvl_ff;
      // stage 0 is only read by stage 1; a change counts when stages 1 and 2 agree
      if (timer_sh_ff[pwr_down_pkg::sync_depth-2] == timer_sh_ff[pwr_down_pkg::sync_depth-1]) begin
         nxt_timer_lvl = timer_sh_ff[pwr_down_pkg::sync_depth-1];
      end
      if (ext_sh_ff[pwr_down_pkg::sync_depth-2] == ext_sh_ff[pwr_down_pkg::sync_depth-1]) begin
         nxt_ext_lvl = ext_sh_ff[pwr_down_pkg::sync_depth-1];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         timer_sh_ff <= '0;
         ext_sh_ff <= '0;
         timer_lvl_ff <= 1'b0;
         ext_lvl_ff <= 1'b0;
      end else begin
         timer_sh_ff <= nxt_timer_sh;
         ext_sh_ff <= nxt_ext_sh;
         timer_lvl_ff <= nxt_timer_lvl;
         ext_lvl_ff <= nxt_ext_lvl;
      end
   end

   assign wake.timer_wake = timer_lvl_ff;
   assign wake.ext_wake = ext_lvl_ff;
endmodule

//--- core/power_down_mode_control.sv
// power-down mode controller: level select, start bit, wake sources, regulator
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module power_down_mode_control (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // software control
   input wire logic [pwr_down_pkg::level_w-1:0] sleep_level_select_in,
   input wire logic sleep_go_wr_in,
   // asynchronous wake pins
   input wire logic timer_irq_pin_in,
   input wire logic ext_irq_pin_in,
   // status
   output logic sleep_go_out,
   output logic [pwr_down_pkg::level_w-1:0] power_level_out,
   output logic sleeping_out,
   output logic dig_reg_on_out,
   output logic reconfig_needed_out,
   output logic wake_pulse_out
);
   wake_if wake ();

   wake_sync u_sync (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .timer_irq_pin_in(timer_irq_pin_in),
      .ext_irq_pin_in(ext_irq_pin_in),
      .wake(wake)
   );

   //////////////////////////////////////////////////////////////////////////
   // control state and the decoded request
   pwr_down_pkg::pd_state_t state_ff;
   pwr_down_pkg::pd_state_t nxt_state;
   pwr_down_pkg::pd_state_t req_state;
   logic sleep_go_ff;
   logic nxt_sleep_go;
   logic wake_now;
   // status registers behind the outputs
   logic [pwr_down_pkg::level_w-1:0] level_ff;
   logic [pwr_down_pkg::level_w-1:0] nxt_level;
   logic sleeping_ff;
   logic nxt_sleeping;
   logic reg_on_ff;
   logic nxt_reg_on;
   logic reconfig_ff;
   logic nxt_reconfig;
   logic wake_ff;
   logic nxt_wake;

   //////////////////////////////////////////////////////////////////////////
   // decode level field
   always_comb begin
      req_state = pwr_down_pkg::st_active;
      case (sleep_level_select_in)
         pwr_down_pkg::level_light: begin
            req_state = pwr_down_pkg::st_light;
         end
         pwr_down_pkg::level_deep: begin
            req_state = pwr_down_pkg::st_deep;
         end
         pwr_down_pkg::level_deepest: begin
            req_state = pwr_down_pkg::st_deepest;
         end
         // level 0 asks for nothing, so a go with it is dropped
         default: begin
            req_state = pwr_down_pkg::st_active;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // light and deep: timer or external
   always_comb begin
      wake_now = 1'b0;
      case (state_ff)
         pwr_down_pkg::st_light: begin
            wake_now = wake.timer_wake | wake.ext_wake;
         end
         pwr_down_pkg::st_deep: begin
            wake_now = wake.timer_wake | wake.ext_wake;
         end
         pwr_down_pkg::st_deepest: begin
            wake_now = wake.ext_wake;
         end
         // nothing to wake from while active
         default: begin
            wake_now = 1'b0;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_state = state_ff;
      nxt_sleep_go = sleep_go_ff;
      case (state_ff)
         pwr_down_pkg::st_active: begin
            if (sleep_go_wr_in && req_state != pwr_down_pkg::st_active) begin
               nxt_state = req_state;
               nxt_sleep_go = 1'b1;
            end
         end
         // a go while asleep is ignored; only a wake leaves a level
         pwr_down_pkg::st_light, pwr_down_pkg::st_deep, pwr_down_pkg::st_deepest: begin
            if (wake_now) begin
               nxt_state = pwr_down_pkg::st_active;
               nxt_sleep_go = 1'b0;
            end
         end
         default: begin
            nxt_state = pwr_down_pkg::st_active;
            nxt_sleep_go = 1'b0;
         end
      endcase
   end

   // hardware reset is itself a wake source: it returns to active at once
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state_ff <= pwr_down_pkg::st_active;
         sleep_go_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sleep_go_ff <= nxt_sleep_go;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // outputs follow the next state so they change on the same edge as it
   always_comb begin
      nxt_level = pwr_down_pkg::level_active;
      nxt_sleeping = 1'b0;
      nxt_reg_on = 1'b1;
      case (nxt_state)
         pwr_down_pkg::st_light: begin
            nxt_level = pwr_down_pkg::level_light;
            nxt_sleeping = 1'b1;
            nxt_reg_on = 1'b1;
         end
         pwr_down_pkg::st_deep: begin
            nxt_level = pwr_down_pkg::level_deep;
            nxt_sleeping = 1'b1;
            nxt_reg_on = 1'b0;
         end
         pwr_down_pkg::st_deepest: begin
            nxt_level = pwr_down_pkg::level_deepest;
            nxt_sleeping = 1'b1;
            nxt_reg_on = 1'b0;
         end
         default: begin
            nxt_level = pwr_down_pkg::level_active;
            nxt_sleeping = 1'b0;
            nxt_reg_on = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         level_ff <= pwr_down_pkg::level_active;
         sleeping_ff <= 1'b0;
         reg_on_ff <= 1'b1;
      end else begin
         level_ff <= nxt_level;
         sleeping_ff <= nxt_sleeping;
         reg_on_ff <= nxt_reg_on;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // deeper levels lose config
   always_comb begin
      nxt_reconfig = reconfig_ff;
      if (nxt_state == pwr_down_pkg::st_deep || nxt_state == pwr_down_pkg::st_deepest) begin
         nxt_reconfig = 1'b1;
      end else if (sleep_go_wr_in && nxt_state == pwr_down_pkg::st_light) begin
         // software has set things up again before it asks for light sleep
         nxt_reconfig = 1'b0;
      end
   end

   // a lost configuration is only noticed if the flag survives the wake
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         reconfig_ff <= 1'b0;
      end else begin
         reconfig_ff <= nxt_reconfig;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // one pulse per pin wake
   always_comb begin
      nxt_wake = wake_now;
   end

   // reset wakes too, but it is not reported here: everything restarts anyway
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         wake_ff <= 1'b0;
      end else begin
         wake_ff <= nxt_wake;
      end
   end

   assign sleep_go_out = sleep_go_ff;
   assign power_level_out = level_ff;
   assign sleeping_out = sleeping_ff;
   assign dig_reg_on_out = reg_on_ff;
   assign reconfig_needed_out = reconfig_ff;
   assign wake_pulse_out = wake_ff;
endmodule

//--- verif/pdmc_props.sv
// assertions for the power-down mode controller
`timescale 1ns/100ps
module pdmc_props (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic [pwr_down_pkg::level_w-1:0] sleep_level_select_in,
   input wire logic sleep_go_wr_in,
   input wire logic timer_irq_pin_in,
   input wire logic ext_irq_pin_in,
   input wire logic sleep_go_out,
   input wire logic [pwr_down_pkg::level_w-1:0] power_level_out,
   input wire logic sleeping_out,
   input wire logic dig_reg_on_out,
   input wire logic reconfig_needed_out,
   input wire logic wake_pulse_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_go; sleep_go_wr_in && !sleeping_out && sleep_level_select_in != 2'h0; endsequence
   sequence s_ext; (sleeping_out && ext_irq_pin_in)[*2]; endsequence
   sequence s_tmr; (sleeping_out && power_level_out != 2'h3 && timer_irq_pin_in)[*2]; endsequence
   // a stale external pulse may still be in the synchroniser, so wait it out
   sequence s_quiet; (power_level_out == 2'h3 && !ext_irq_pin_in)[*6]; endsequence
   property p_go;
      s_go |=> sleeping_out && sleep_go_out
         && power_level_out == $past(sleep_level_select_in);
   endproperty
   a_go: assert property (p_go) else $error("sleep entry wrong");
   property p_idle; !sleeping_out && !sleep_go_wr_in |=> !sleeping_out; endproperty
   a_idle: assert property (p_idle) else $error("sleep without go");
   property p_ext; s_ext |-> ##[1:8] wake_pulse_out; endproperty
   a_ext: assert property (p_ext) else $error("no external wake");
   property p_tmr; s_tmr |-> ##[1:8] !sleeping_out; endproperty
   a_tmr: assert property (p_tmr) else $error("no timer wake");
   property p_deepest_hold; s_quiet |=> power_level_out == 2'h3; endproperty
   a_deepest_hold: assert property (p_deepest_hold) else $error("deepest left early");
   property p_reg; dig_reg_on_out == (power_level_out < 2'h2); endproperty
   a_reg: assert property (p_reg) else $error("regulator wrong");
   property p_wake;
      wake_pulse_out |-> !sleeping_out && !sleep_go_out && power_level_out == 2'h0;
   endproperty
   a_wake: assert property (p_wake) else $error("wake not cleared");
endmodule
bind power_down_mode_control pdmc_props chk_u (.*);

//--- verif/wake_src_model.sv
// sleep timer and external interrupt pin model
`timescale 1ns/100ps
module wake_src_model (
   input wire logic core_clk_in,
   input wire logic timer_fire_in,
   input wire logic ext_fire_in,
   output logic timer_irq_pin_out = 1'b0,
   output logic ext_irq_pin_out = 1'b0
);
   // driven on the rising edge like every input; the core still treats them as foreign
   always @(posedge core_clk_in) begin
      timer_irq_pin_out <= timer_fire_in;
      ext_irq_pin_out <= ext_fire_in;
   end
endmodule

//--- verif/tb_power_down_mode_control.sv
// self-checking bench for the power-down mode controller
`timescale 1ns/100ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_power_down_mode_control;
   logic clk = 1'b0, rst = 1'b1, go = 1'b0, t_fire = 1'b0, e_fire = 1'b0;
   logic [1:0] sel = 2'h0, lvl;
   logic t_pin, e_pin, go_o, slp, reg_on, rcfg, wk;
   int n_errors = 0, compares = 0;
   power_down_mode_control dut_u (.core_clk_in(clk), .sys_rst_in(rst), .sleep_level_select_in(sel),
      .sleep_go_wr_in(go), .timer_irq_pin_in(t_pin), .ext_irq_pin_in(e_pin), .sleep_go_out(go_o),
      .power_level_out(lvl), .sleeping_out(slp), .dig_reg_on_out(reg_on),
      .reconfig_needed_out(rcfg), .wake_pulse_out(wk));
   wake_src_model src_u (.core_clk_in(clk), .timer_fire_in(t_fire), .ext_fire_in(e_fire),
      .timer_irq_pin_out(t_pin), .ext_irq_pin_out(e_pin));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic stop_test();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // pins settle first; level is moved after go to show it is ignored
   task automatic enter(input logic [1:0] l);
      repeat (8) @(posedge clk);
      sel <= l;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      sel <= ~l;
      @(negedge clk);
   endtask
   task automatic wait_wake();
      for (int n = 0; n < 20 && slp !== 1'b0; n++) @(negedge clk);
      `CHK("sleeping", 1'b0, slp)
      `CHK("wake pulse", 1'b1, wk)
      `CHK("sleep_go", 1'b0, go_o)
      `CHK("level", 2'h0, lvl)
      `CHK("reg back on", 1'b1, reg_on)
      @(negedge clk);
      `CHK("pulse width", 1'b0, wk)
      @(posedge clk);
      t_fire <= 1'b0;
      e_fire <= 1'b0;
   endtask
   task automatic t_light();
      enter(2'h1);
      `CHK("light", 2'h1, lvl)
      `CHK("reg on", 1'b1, reg_on)
      `CHK("reconfig clear", 1'b0, rcfg)
      @(posedge clk);
      sel <= 2'h3;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      `CHK("go while asleep", 2'h1, lvl)
      t_fire <= 1'b1;
      wait_wake();
      $display("light done");
   endtask
   task automatic t_deep();
      enter(2'h2);
      `CHK("deep", 2'h2, lvl)
      `CHK("reg off", 1'b0, reg_on)
      `CHK("reconfig set", 1'b1, rcfg)
      e_fire <= 1'b1;
      wait_wake();
      `CHK("reconfig kept", 1'b1, rcfg)
      enter(2'h2);
      t_fire <= 1'b1;
      wait_wake();
      $display("deep done");
   endtask
   task automatic t_deepest();
      enter(2'h3);
      `CHK("deepest", 2'h3, lvl)
      `CHK("reg off deepest", 1'b0, reg_on)
      `CHK("reconfig deepest", 1'b1, rcfg)
      t_fire <= 1'b1;
      repeat (12) @(negedge clk);
      `CHK("timer ignored", 2'h3, lvl)
      `CHK("no pulse", 1'b0, wk)
      e_fire <= 1'b1;
      wait_wake();
      $display("deepest done");
   endtask
   task automatic t_nogo();
      enter(2'h0);
      `CHK("no sleep", 1'b0, slp)
      repeat (3) @(negedge clk);
      `CHK("level alone", 1'b0, slp)
      enter(2'h2);
      `CHK("go set", 1'b1, go_o)
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK("reset wake", 1'b0, slp)
      `CHK("reset go", 1'b0, go_o)
      `CHK("reset reg", 1'b1, reg_on)
      `CHK("reset reconfig", 1'b0, rcfg)
      `CHK("reset pulse", 1'b0, wk)
      $display("reset wake done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_deep();
      t_light();
      t_deepest();
      t_nogo();
      stop_test();
   end
   // whole run is about 110 cycles; the limit allows 2500
   initial begin
      #20000;
      n_errors++;
      stop_test();
   end
endmodule
